// ### inc/rps_defines.svh
// Register offsets, field layouts, reset values and key codes of the pin router.
`ifndef RPS_DEFINES_SVH
`define RPS_DEFINES_SVH
`define RPS_IN_BASE    8'h00
`define RPS_OUT_BASE   8'h80
`define RPS_OSC_ADDR   8'hc0
`define RPS_ALT_ADDR   8'hc4
`define RPS_STAT_ADDR  8'hc8
`define RPS_KEY1       8'h46
`define RPS_KEY2       8'h57
`define RPS_LOCK_BIT   6
`define RPS_FUSE_BIT   4
`define RPS_SCK_BIT    0
`define RPS_FLD_LO     0
`define RPS_FLD_HI     8
`define RPS_IN_RST     6'h3f
`define RPS_OUT_RST    6'h00
`define RPS_MAX_PIN    6'h2d
`define RPS_SCK1_FN    6'h08
`define RPS_IN_REGS    21
`define RPS_OUT_REGS   16
`define RPS_NUM_PINS   46
`define RPS_NUM_FN     37
`endif

// ### inc/rps_pkg.sv
// Types shared by the pin router modules.
package rps_pkg;
    // Unlock sequence progress, one-hot.
    typedef enum logic [2:0]
    {
        RPS_SEQ_IDLE = 3'b001,
        RPS_SEQ_KEY1 = 3'b010,
        RPS_SEQ_KEY2 = 3'b100
    } rps_seq_t;
    // One six-bit select field.
    typedef logic [5:0] rps_sel_t;
endpackage

// ### hw/rps_route.sv
// Combinational routing matrix between remappable pins and peripherals.
`include "rps_defines.svh"
module rps_route
    import rps_pkg::*;
#(
    parameter int NI  = 42,
    parameter int NP  = 46,
    parameter int NIO = 32,
    parameter int NF  = 37
)
(
    input  wire logic [NI-1:0][5:0]  in_sel,
    input  wire logic [NIO-1:0][5:0] out_sel,
    input  wire logic [NP-1:0]       pin_in,
    input  wire logic [NP-1:0]       pin_impl,
    input  wire logic [NP-1:0]       pin_analog,
    input  wire logic [NF-1:0]       periph_out,
    input  wire logic                sck_alt,
    output logic      [NI-1:0]       periph_in_d,
    output logic      [NIO-1:0]      pin_out_d,
    output logic      [NIO-1:0]      pin_oe_d,
    output logic                     sck_pin_d
);
    // Each peripheral input picks exactly one pin, so two pins can never fight
    // over one input; codes past the last pin or naming a missing pin read low.
    always_comb
    begin
        for (int k = 0; k < NI; k++)
        begin
            periph_in_d[k] = 1'b0;
            for (int p = 0; p < NP; p++)
            begin
                // Analog pins feed no digital value into the matrix.
                if (in_sel[k] == 6'(p) && pin_impl[p] && !pin_analog[p])
                begin
                    periph_in_d[k] = pin_in[p];
                end
            end
        end
    end

    // Each output-capable pin picks one function; the null code and unknown codes leave it undriven.
    always_comb
    begin
        for (int p = 0; p < NIO; p++)
        begin
            pin_out_d[p] = 1'b0;
            pin_oe_d[p]  = 1'b0;
            for (int f = 1; f < NF; f++)
            begin
                if (out_sel[p] == 6'(f))
                begin
                    pin_out_d[p] = periph_out[f];
                    pin_oe_d[p]  = !pin_analog[p];
                end
            end
        end
        sck_pin_d = sck_alt & periph_out[`RPS_SCK1_FN];
    end
endmodule

// ### hw/rps_top.sv
// Remappable pin router: AHB-Lite registers, write lock, shadows and outputs.
`include "rps_defines.svh"
module rps_top
    import rps_pkg::*;
#(
    parameter int              IN_REGS  = `RPS_IN_REGS,
    parameter int              OUT_REGS = `RPS_OUT_REGS,
    parameter int              NUM_PINS = `RPS_NUM_PINS,
    parameter int              NUM_FN   = `RPS_NUM_FN,
    parameter logic [45:0]     PIN_IMPL = {46{1'b1}}
)
(
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic                  hready,
    input  wire logic [31:0]           hwdata,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic [15:0]           config_word_two,
    input  wire logic [NUM_PINS-1:0]   pin_in,
    input  wire logic [NUM_PINS-1:0]   pin_analog,
    input  wire logic [NUM_FN-1:0]     periph_out,
    output logic      [2*IN_REGS-1:0]  periph_in,
    output logic      [2*OUT_REGS-1:0] pin_out,
    output logic      [2*OUT_REGS-1:0] pin_oe,
    output logic                       fixed_spi1_clk_pin,
    output logic                       cfg_mismatch_rst,
    output logic                       map_write_lock
);
    localparam int NI  = 2 * IN_REGS;  // Peripheral inputs, two per register.
    localparam int NIO = 2 * OUT_REGS; // Output-capable pins, two per register.

    // The six-bit code space and the word map cannot serve larger settings.
    if (NUM_PINS > 64 || NUM_PINS < NIO || IN_REGS > 32 || OUT_REGS > 16
        || NUM_FN > 64 || NUM_FN <= `RPS_SCK1_FN)
    begin : g_bad_params
        $error("rps_top: parameter values out of range");
    end

    // Select storage and its shadow copies.
    rps_sel_t [NI-1:0]   in_sel;       // Input-select fields.
    rps_sel_t [NIO-1:0]  out_sel;      // Output-select fields.
    rps_sel_t [NI-1:0]   in_shd;       // Shadow of the input fields.
    rps_sel_t [NIO-1:0]  out_shd;      // Shadow of the output fields.
    rps_sel_t [NI-1:0]   next_in_sel;
    rps_sel_t [NIO-1:0]  next_out_sel;
    rps_sel_t [NI-1:0]   next_in_shd;
    rps_sel_t [NIO-1:0]  next_out_shd;

    // Lock and unlock state.
    rps_seq_t            seq;          // Unlock sequence progress.
    rps_seq_t            next_seq;
    logic                next_lock;
    logic                once_set;     // Lock has been set since reset.
    logic                next_once_set;
    logic                fuse;         // Single-session fuse caught at reset.
    logic                sck_alt;      // Fixed SPI1 clock route bit.
    logic                next_sck_alt;
    logic                next_mismatch;

    // Bus state.
    logic                wr_pend;      // Write data phase in progress.
    logic                rd_pend;      // Read data phase in progress.
    logic [7:0]          a_q;          // Latched byte address of the transfer.
    logic                next_wr_pend;
    logic                next_rd_pend;
    logic [7:0]          next_a_q;
    logic                next_hreadyout;
    logic [31:0]         next_hrdata;
    logic                acc;          // Transfer accepted this cycle.

    // Router results before the output flops.
    logic [NI-1:0]       periph_in_d;
    logic [NIO-1:0]      pin_out_d;
    logic [NIO-1:0]      pin_oe_d;
    logic                sck_pin_d;

    // Byte address of a select register, shared by decode and read mux.
    function automatic logic [7:0] word_addr(input logic [7:0] base, input int idx);
        word_addr = base + 8'(idx * 4);
    endfunction

    // Whether output pin p exists on this device; missing pins keep no bits.
    function automatic logic out_impl(input int p);
        out_impl = PIN_IMPL[p];
    endfunction

    // Read value of the word at address a; unmapped words read zero.
    function automatic logic [31:0] read_word(input logic [7:0] a);
        read_word = 32'h0000_0000;
        for (int i = 0; i < IN_REGS; i++)
        begin
            if (a == word_addr(`RPS_IN_BASE, i))
            begin
                read_word[`RPS_FLD_LO +: 6] = in_sel[2*i];
                read_word[`RPS_FLD_HI +: 6] = in_sel[2*i+1];
            end
        end
        for (int j = 0; j < OUT_REGS; j++)
        begin
            if (a == word_addr(`RPS_OUT_BASE, j))
            begin
                read_word[`RPS_FLD_LO +: 6] = out_sel[2*j];
                read_word[`RPS_FLD_HI +: 6] = out_sel[2*j+1];
            end
        end
        if (a == `RPS_OSC_ADDR)
        begin
            read_word[`RPS_LOCK_BIT] = map_write_lock;
        end
        if (a == `RPS_ALT_ADDR)
        begin
            read_word[`RPS_SCK_BIT] = sck_alt;
        end
        if (a == `RPS_STAT_ADDR)
        begin
            // Status: lock, once-set, fuse, then the sequence state.
            read_word[0]   = map_write_lock;
            read_word[1]   = once_set;
            read_word[2]   = fuse;
            read_word[6:4] = seq;
        end
    endfunction

    // Address phase is taken only for real transfers on a ready bus.
    assign acc = hsel & hready & htrans[1];

    // Bus sequencing: writes take no wait state, reads take one so the read
    // data always reflects a write finished in the cycle just before.
    always_comb
    begin
        next_wr_pend   = wr_pend;
        next_rd_pend   = rd_pend;
        next_a_q       = a_q;
        next_hreadyout = hreadyout;
        next_hrdata    = hrdata;
        if (rd_pend)
        begin
            // Second data-phase cycle: present data and release the bus.
            next_hrdata    = read_word(a_q);
            next_rd_pend   = 1'b0;
            next_hreadyout = 1'b1;
        end
        else if (hready)
        begin
            next_wr_pend = acc & hwrite;
            next_rd_pend = acc & ~hwrite;
            next_a_q     = acc ? {haddr[7:2], 2'b00} : a_q;
            // A read stalls its first data-phase cycle.
            next_hreadyout = ~(acc & ~hwrite);
        end
    end

    // Bus flops.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            a_q       <= 8'h00;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end
        else if (clk_en)
        begin
            wr_pend   <= next_wr_pend;
            rd_pend   <= next_rd_pend;
            a_q       <= next_a_q;
            hreadyout <= next_hreadyout;
            hrdata    <= next_hrdata;
            hresp     <= 1'b0;
        end
    end

    // Unlock sequence and lock bit. Only bus writes advance or abort the
    // sequence; reads between the keys are harmless.
    always_comb
    begin
        next_seq      = seq;
        next_lock     = map_write_lock;
        next_once_set = once_set;
        next_sck_alt  = sck_alt;
        if (wr_pend)
        begin
            next_seq = RPS_SEQ_IDLE;
            if (a_q == `RPS_OSC_ADDR)
            begin
                case (seq)
                    RPS_SEQ_IDLE:
                    begin
                        // A spent single session ignores the keys entirely.
                        if (hwdata[7:0] == `RPS_KEY1 && !(fuse && once_set))
                        begin
                            next_seq = RPS_SEQ_KEY1;
                        end
                    end
                    RPS_SEQ_KEY1:
                    begin
                        if (hwdata[7:0] == `RPS_KEY2)
                        begin
                            next_seq = RPS_SEQ_KEY2;
                        end
                    end
                    RPS_SEQ_KEY2:
                    begin
                        // The lock changes in this single write only.
                        next_lock = hwdata[`RPS_LOCK_BIT];
                        next_once_set = once_set | hwdata[`RPS_LOCK_BIT];
                    end
                    default:
                    begin
                        next_seq = RPS_SEQ_IDLE;
                    end
                endcase
            end
            if (a_q == `RPS_ALT_ADDR)
            begin
                // Not gated by the lock; software owns its timing.
                next_sck_alt = hwdata[`RPS_SCK_BIT];
            end
        end
    end

    // Lock flops; the fuse is caught while reset is held.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            seq            <= RPS_SEQ_IDLE;
            map_write_lock <= 1'b0;
            once_set       <= 1'b0;
            sck_alt        <= 1'b0;
            fuse           <= config_word_two[`RPS_FUSE_BIT];
        end
        else if (clk_en)
        begin
            seq            <= next_seq;
            map_write_lock <= next_lock;
            once_set       <= next_once_set;
            sck_alt        <= next_sck_alt;
        end
    end

    // Select register writes. Shadows follow only legal writes, so any other
    // change of a select bit shows up as a difference.
    always_comb
    begin
        next_in_sel  = in_sel;
        next_out_sel = out_sel;
        next_in_shd  = in_shd;
        next_out_shd = out_shd;
        if (wr_pend && !map_write_lock)
        begin
            for (int i = 0; i < IN_REGS; i++)
            begin
                if (a_q == word_addr(`RPS_IN_BASE, i))
                begin
                    next_in_sel[2*i]   = hwdata[`RPS_FLD_LO +: 6];
                    next_in_sel[2*i+1] = hwdata[`RPS_FLD_HI +: 6];
                end
            end
            for (int j = 0; j < OUT_REGS; j++)
            begin
                if (a_q == word_addr(`RPS_OUT_BASE, j))
                begin
                    // Fields of absent pins stay at zero.
                    if (out_impl(2*j))
                    begin
                        next_out_sel[2*j] = hwdata[`RPS_FLD_LO +: 6];
                    end
                    if (out_impl(2*j+1))
                    begin
                        next_out_sel[2*j+1] = hwdata[`RPS_FLD_HI +: 6];
                    end
                end
            end
            next_in_shd  = next_in_sel;
            next_out_shd = next_out_sel;
        end
        // A registered reset request, held for as long as any field disagrees.
        next_mismatch = (in_sel != in_shd) || (out_sel != out_shd);
    end

    // Select and shadow flops.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            in_sel           <= {NI{`RPS_IN_RST}};
            in_shd           <= {NI{`RPS_IN_RST}};
            out_sel          <= {NIO{`RPS_OUT_RST}};
            out_shd          <= {NIO{`RPS_OUT_RST}};
            cfg_mismatch_rst <= 1'b0;
        end
        else if (clk_en)
        begin
            in_sel           <= next_in_sel;
            in_shd           <= next_in_shd;
            out_sel          <= next_out_sel;
            out_shd          <= next_out_shd;
            cfg_mismatch_rst <= next_mismatch;
        end
    end

    // Routing matrix. It only steers data: peripheral enables and pin
    // direction settings elsewhere are untouched.
    rps_route #(
        .NI  (NI),
        .NP  (NUM_PINS),
        .NIO (NIO),
        .NF  (NUM_FN)
    ) u_route (
        .in_sel      (in_sel),
        .out_sel     (out_sel),
        .pin_in      (pin_in),
        .pin_impl    (PIN_IMPL[NUM_PINS-1:0]),
        .pin_analog  (pin_analog),
        .periph_out  (periph_out),
        .sck_alt     (sck_alt),
        .periph_in_d (periph_in_d),
        .pin_out_d   (pin_out_d),
        .pin_oe_d    (pin_oe_d),
        .sck_pin_d   (sck_pin_d)
    );

    // Routed outputs are registered, adding one cycle of latency each way.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            periph_in          <= '0;
            pin_out            <= '0;
            pin_oe             <= '0;
            fixed_spi1_clk_pin <= 1'b0;
        end
        else if (clk_en)
        begin
            periph_in          <= periph_in_d;
            pin_out            <= pin_out_d;
            pin_oe             <= pin_oe_d;
            fixed_spi1_clk_pin <= sck_pin_d;
        end
    end
endmodule

// ### bench/rps_assertions.sv
// Concurrent checks on the ports of the pin router.
`include "rps_defines.svh"
module rps_assertions
#(
    parameter int IN_REGS  = 21,
    parameter int OUT_REGS = 16,
    parameter int NUM_PINS = 46,
    parameter int NUM_FN   = 37
)
(
    input wire logic                  clk,
    input wire logic                  reset,
    input wire logic                  clk_en,
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic                  hready,
    input wire logic [31:0]           hrdata,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic [NUM_PINS-1:0]   pin_analog,
    input wire logic [NUM_FN-1:0]     periph_out,
    input wire logic [2*IN_REGS-1:0]  periph_in,
    input wire logic [2*OUT_REGS-1:0] pin_oe,
    input wire logic                  fixed_spi1_clk_pin,
    input wire logic                  cfg_mismatch_rst,
    input wire logic                  map_write_lock
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Transfers that the slave takes at this edge.
    wire rd_take  = clk_en && hsel && hready && htrans[1] && !hwrite;
    wire wr_take  = clk_en && hsel && hready && htrans[1] && hwrite;
    wire osc_take = wr_take && (haddr[7:0] == `RPS_OSC_ADDR);
    AST_READ_ONE_WAIT: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait state");
    AST_WRITE_NO_WAIT: assert property (wr_take |=> hreadyout)
        else $error("write data phase was stretched");
    AST_ALWAYS_OKAY: assert property (hresp == 1'b0)
        else $error("slave answered with an error response");
    AST_RDATA_HOLD: assert property ((hreadyout && $past(hreadyout)) |->
        $stable(hrdata))
        else $error("read data moved without a read");
    // A frozen block keeps stale outputs while the far side moves, so only
    // outputs loaded on an enabled edge are judged against their sources.
    AST_ANALOG_UNDRIVEN: assert property ($past(clk_en) |->
        ((pin_oe & $past(pin_analog[2*OUT_REGS-1:0])) == '0))
        else $error("analog pin was driven by routing");
    AST_FIXED_CLK_SRC: assert property (($past(clk_en) && fixed_spi1_clk_pin) |->
        $past(periph_out[8]))
        else $error("fixed clock pin high without its source");
    // Reset itself is the cause here, so this one is never disabled.
    AST_RESET_STATE: assert property (disable iff (1'b0) reset |=>
        (pin_oe == '0 && periph_in == '0 && !map_write_lock && hreadyout))
        else $error("outputs not in reset state");
    AST_NO_MISMATCH: assert property (!cfg_mismatch_rst)
        else $error("configuration mismatch raised by legal traffic");
    AST_LOCK_BY_WRITE: assert property ($changed(map_write_lock) |->
        $past(osc_take, 2))
        else $error("lock changed without an oscillator control write");
    cover property ($rose(map_write_lock));
    cover property ($fell(map_write_lock));
    cover property (rd_take);
    cover property (fixed_spi1_clk_pin);
endmodule

bind rps_top rps_assertions #(.IN_REGS(IN_REGS), .OUT_REGS(OUT_REGS), .NUM_PINS(NUM_PINS),
    .NUM_FN(NUM_FN)) chk_u (.clk(clk), .reset(reset), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_analog(pin_analog), .periph_out(periph_out),
    .periph_in(periph_in), .pin_oe(pin_oe), .fixed_spi1_clk_pin(fixed_spi1_clk_pin),
    .cfg_mismatch_rst(cfg_mismatch_rst), .map_write_lock(map_write_lock));

// ### bench/rps_far_model.sv
// Far-side model: remappable pin levels, analog settings and peripheral outputs.
module rps_far_model
(
    input  wire logic        clk,
    input  wire logic [45:0] pin_set,
    input  wire logic [45:0] ana_set,
    input  wire logic [36:0] fn_set,
    output logic      [45:0] pin_in,
    output logic      [45:0] pin_analog,
    output logic      [36:0] periph_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins and peripherals launch from flops, so they move only after an edge.
    // The analog choice lives here, apart from routing.
    always_ff @(posedge clk)
    begin
        pin_in     <= pin_set;
        pin_analog <= ana_set;
        periph_out <= fn_set;
    end
endmodule

// ### bench/tb_remappable_pin_select_with_lock.sv
// Self-checking testbench for the remappable pin router.
`include "rps_defines.svh"
module tb_remappable_pin_select_with_lock;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset, hsel, hwrite, hreadyout, hresp, fixed_spi1_clk_pin;
    logic        cfg_mismatch_rst, map_write_lock, clk_en;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] config_word_two;
    logic [45:0] pin_in, pin_analog, pin_set, ana_set;
    logic [36:0] periph_out, fn_set;
    logic [41:0] periph_in;
    logic [31:0] pin_out, pin_oe;
    int          bad_count = 0;
    int          n_tests   = 0;
    // Pin 3 is left out so the absent-pin paths get exercised.
    rps_top #(.PIN_IMPL(46'h3ffffffffff7)) dut_u (.clk(clk), .reset(reset), .clk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .config_word_two(config_word_two), .pin_in(pin_in),
        .pin_analog(pin_analog), .periph_out(periph_out), .periph_in(periph_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .fixed_spi1_clk_pin(fixed_spi1_clk_pin),
        .cfg_mismatch_rst(cfg_mismatch_rst), .map_write_lock(map_write_lock));
    rps_far_model far_u (.clk(clk), .pin_set(pin_set), .ana_set(ana_set), .fn_set(fn_set),
        .pin_in(pin_in), .pin_analog(pin_analog), .periph_out(periph_out));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Prints the verdict; the only place where the run ends.
    task automatic complete_run();
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: register read %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic chk_port(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: port value %h, wanted %h", $time, got, exp);
        end
    endtask
    // One single AHB transfer; every wait ends on hready, never on a cycle count.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        haddr  <= {24'h0, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, q);
    endtask
    // Outputs trail the far model by one edge and the selects by one edge as well.
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask
    task automatic unlock(input logic [31:0] d);
        wr(`RPS_OSC_ADDR, 32'h46);
        wr(`RPS_OSC_ADDR, 32'h57);
        wr(`RPS_OSC_ADDR, d);
    endtask
    // The fuse is only taken while reset is high, so it is set up first.
    task automatic do_reset(input logic [15:0] cw);
        config_word_two <= cw;
        reset           <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_reset_state();
        xfer(1'b0, `RPS_IN_BASE, 0, q);
        chk_reg(q, 32'h00003f3f);
        xfer(1'b0, `RPS_OUT_BASE, 0, q);
        chk_reg(q, 32'h0);
        xfer(1'b0, `RPS_OSC_ADDR, 0, q);
        chk_reg(q, 32'h0);
        xfer(1'b0, `RPS_STAT_ADDR, 0, q);
        chk_reg(q & 32'h4, 32'h4);
        xfer(1'b0, 8'hf0, 0, q);
        chk_reg(q, 32'h0);
        chk_port(64'(periph_in), 64'h0);
        chk_port(64'(pin_oe), 64'h0);
    endtask
    // Pin 40 is input only, code 2eh lies past the last pin, pin 3 is absent.
    task automatic t_input_route();
        pin_set <= 46'h10000000028;
        wr(`RPS_IN_BASE, 32'h00002805);
        wr(`RPS_IN_BASE + 8'h4, 32'h00000505);
        wr(`RPS_IN_BASE + 8'h8, 32'h0000032e);
        settle();
        chk_port(64'(periph_in), 64'h0f);
        ana_set <= 46'h20;
        settle();
        chk_port(64'(periph_in), 64'h02);
        // A low clock enable must hold the routed inputs while the analog settings move.
        clk_en  <= 1'b0;
        ana_set <= 46'h0;
        settle();
        chk_port(64'(periph_in), 64'h02);
        clk_en <= 1'b1;
        settle();
        chk_port(64'(periph_in), 64'h0f);
    endtask
    task automatic t_output_route();
        fn_set <= 37'h108;
        wr(`RPS_OUT_BASE, 32'h00000303);
        wr(`RPS_OUT_BASE + 8'h4, 32'h00000300);
        wr(`RPS_OUT_BASE + 8'h8, 32'h00000825);
        xfer(1'b0, `RPS_OUT_BASE + 8'h4, 0, q);
        chk_reg(q, 32'h0);
        settle();
        chk_port(64'(pin_oe), 64'h23);
        chk_port(64'(pin_out), 64'h23);
        ana_set <= 46'h2;
        settle();
        chk_port(64'(pin_oe), 64'h21);
        ana_set <= 46'h0;
    endtask
    // Software owns the route bit around SPI1 activity.
    task automatic t_alt_clock();
        wr(`RPS_ALT_ADDR, 32'h1);
        settle();
        chk_port(64'(fixed_spi1_clk_pin), 64'h1);
        wr(`RPS_ALT_ADDR, 32'h0);
        settle();
        chk_port(64'(fixed_spi1_clk_pin), 64'h0);
    endtask
    task automatic t_lock_once();
        unlock(32'h40);
        xfer(1'b0, `RPS_OSC_ADDR, 0, q);
        chk_reg(q, 32'h40);
        wr(`RPS_IN_BASE, 32'h0);
        xfer(1'b0, `RPS_IN_BASE, 0, q);
        chk_reg(q, 32'h00002805);
        unlock(32'h0);
        settle();
        chk_port(64'(map_write_lock), 64'h1);
    endtask
    task automatic t_lock_multi();
        wr(`RPS_OSC_ADDR, 32'h46);
        wr(`RPS_ALT_ADDR, 32'h0);
        wr(`RPS_OSC_ADDR, 32'h57);
        wr(`RPS_OSC_ADDR, 32'h40);
        settle();
        chk_port(64'(map_write_lock), 64'h0);
        unlock(32'h40);
        wr(`RPS_ALT_ADDR, 32'h0);
        settle();
        chk_port(64'(map_write_lock), 64'h1);
        unlock(32'h0);
        wr(`RPS_IN_BASE, 32'h00000101);
        xfer(1'b0, `RPS_IN_BASE, 0, q);
        chk_reg(q, 32'h00000101);
    endtask
    initial
    begin
        clk_en = 1'b1;
        hsel   = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        haddr  = 32'h0;
        hwdata = 32'h0;
        pin_set = 46'h0;
        ana_set = 46'h0;
        fn_set  = 37'h0;
        do_reset(16'h0010);
        t_reset_state();
        t_input_route();
        t_output_route();
        t_alt_clock();
        t_lock_once();
        do_reset(16'h0000);
        t_lock_multi();
        complete_run();
    end
    // The whole sequence needs well under two thousand cycles.
    initial
    begin
        #100000;
        bad_count++;
        complete_run();
    end
endmodule
